// *** core/cpu_slice.sv ***
/*
 * Flag, low-power, break and branch slice of an 8-bit core, driven by
 * software over APB: write an operand, then an opcode to issue it.
 * Assumes one clock pclk at 200 MHz; interrupt and break pins are asynchronous.
 */
// The implementer's own choices: the register addresses and register access over APB.
// Functional notes
// - Carry set on add carry out of bit 7 or subtract borrow.
// - Wait clears mask, gates clock; interrupt exit keeps mask clear, reset sets it.
// - Stop clears mask, gates clock; external interrupt exit keeps mask, reset sets.
// - After stop exit, clock stays off until stabilization delay elapses.
// - Break start forces software trap opcode into instruction register.
// - Break loads PC with FFFC, or FEFC in monitor mode.
// - Break starts after current instruction; match on final cycle starts immediately.
// - Interrupt return in break routine ends break once request is deasserted.
// - Opcode A7 adds sign-extended operand to stack pointer, 2 cycles, flags kept.
// - Opcode AF adds sign-extended operand to index pair, 2 cycles, flags kept.
// - Opcode 24 branches if carry clear to PC plus 2 plus offset, 3 cycles.
// - Opcode 25 branches if carry set, same target, 3 cycles.
// - Opcode 27 branches if zero set, 3 cycles, flags kept.
// - Opcode 90 branches if negative XOR overflow is zero, 3 cycles.
// - Opcode 92 branches if zero OR (negative XOR overflow) is zero.
// - Opcodes 28 and 29 branch on half-carry clear or set, 3 cycles.
// - Reset sets mask; only clear-mask, wait, stop, or a return restoring a clear saved mask, clear it.
`include "cpu_slice_regs.svh"
module cpu_slice #(
   parameter int STAB_COUNT = `STAB_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_n,
   input wire logic break_req,
   output logic core_clk_en,
   output logic break_active
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   cpu_slice_pkg::exec_state_t state_reg;
   logic [7:0] ir_reg, operand_reg, acc_reg, ccr_reg;
   logic [15:0] sp_reg, hx_reg, pc_reg;
   logic [3:0] cyc_reg;
   logic [12:0] stab_reg;
   logic monitor_reg, saved_mask_reg, illegal_reg;
   logic irq_sync_n, brk_sync;
   logic setup, wr_en, issue_wr, last_cycle, break_start;
   logic is_branch, br_taken;
   logic [15:0] br_target, imm_sext;
   logic [8:0] add_sum, sub_diff;
   logic addr_ok;
   logic [31:0] rd_mux;

   // ------------------------------------------------------------
   // Pin synchronisers and branch evaluator
   // ------------------------------------------------------------
   sync_bit #(.RESET_VAL(1'b1)) u_irq_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(irq_n),
      .q(irq_sync_n)
   );

   sync_bit #(.RESET_VAL(1'b0)) u_brk_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(break_req),
      .q(brk_sync)
   );

   branch_eval u_branch (
      .opcode(ir_reg),
      .ccr(ccr_reg),
      .pc(pc_reg),
      .offset(operand_reg),
      .is_branch(is_branch),
      .taken(br_taken),
      .target(br_target)
   );

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction

   function automatic logic [3:0] cycles_of(input logic [7:0] op);
      logic [3:0] c;
      c = `CYC_ILLEGAL;
      case (op)
         `OP_STACK_ADD, `OP_INDEX_ADD, `OP_ADD_IMM, `OP_SUB_IMM: c = `CYC_IMM_ADD;
         `OP_NO_CARRY, `OP_CARRY, `OP_ZERO, `OP_NO_HALF, `OP_HALF,
         `OP_SIGNED_GE, `OP_SIGNED_GT: c = `CYC_BRANCH;
         `OP_CLEAR_MASK, `OP_SET_MASK: c = `CYC_MASK;
         `OP_WAIT, `OP_STOP: c = `CYC_LOWPOWER;
         `OP_TRAP: c = `CYC_TRAP;
         `OP_RETURN: c = `CYC_RETURN;
         default: c = `CYC_ILLEGAL;
      endcase
      return c;
   endfunction

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite & addr_ok;
   assign issue_wr = wr_en & (paddr == `OFS_ISSUE) & pstrb[0];
   assign last_cycle = (state_reg == cpu_slice_pkg::ST_EXEC) && (cyc_reg == 4'h0);
   // Break waits for the instruction in flight; on its last cycle it starts at once
   assign break_start = brk_sync & ~break_active &
                        (last_cycle | (state_reg == cpu_slice_pkg::ST_IDLE));
   assign imm_sext = {{8{operand_reg[7]}}, operand_reg};
   assign add_sum = {1'b0, acc_reg} + {1'b0, operand_reg};
   assign sub_diff = {1'b0, acc_reg} - {1'b0, operand_reg};

   always_comb
   begin
      addr_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `OFS_CTRL: rd_mux = {31'h0000_0000, monitor_reg};
         `OFS_OPERAND: rd_mux = {24'h00_0000, operand_reg};
         `OFS_ISSUE: rd_mux = {24'h00_0000, ir_reg};
         `OFS_CCR: rd_mux = {24'h00_0000, ccr_reg};
         `OFS_ACC: rd_mux = {24'h00_0000, acc_reg};
         `OFS_SP: rd_mux = {16'h0000, sp_reg};
         `OFS_HX: rd_mux = {16'h0000, hx_reg};
         `OFS_PC: rd_mux = {16'h0000, pc_reg};
         `OFS_STATUS: rd_mux = {25'h000_0000, illegal_reg, core_clk_en, break_active,
                                state_reg == cpu_slice_pkg::ST_STAB,
                                state_reg == cpu_slice_pkg::ST_STOP,
                                state_reg == cpu_slice_pkg::ST_WAIT,
                                state_reg == cpu_slice_pkg::ST_EXEC};
         default: addr_ok = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------
   // Answer is registered so pready and prdata come from flops; no wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~addr_ok;
         prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Software-only registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         monitor_reg <= 1'b0;
         operand_reg <= 8'h00;
      end
      else
      begin
         if (wr_en && paddr == `OFS_CTRL && pstrb[0])
            monitor_reg <= pwdata[0];
         // Operand is frozen while an instruction uses it
         if (wr_en && paddr == `OFS_OPERAND && pstrb[0] && state_reg == cpu_slice_pkg::ST_IDLE)
            operand_reg <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Execution sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= cpu_slice_pkg::ST_IDLE;
         cyc_reg <= 4'h0;
         stab_reg <= 13'h0000;
         core_clk_en <= 1'b1;
      end
      else
      begin
         case (state_reg)
            cpu_slice_pkg::ST_IDLE:
            begin
               if (issue_wr && !break_start)
               begin
                  state_reg <= cpu_slice_pkg::ST_EXEC;
                  cyc_reg <= cycles_of(pwdata[7:0]) - 4'h1;
               end
            end
            cpu_slice_pkg::ST_EXEC:
            begin
               if (cyc_reg != 4'h0)
                  cyc_reg <= cyc_reg - 4'h1;
               else if (break_start)
                  state_reg <= cpu_slice_pkg::ST_IDLE;
               else if (ir_reg == `OP_WAIT)
               begin
                  state_reg <= cpu_slice_pkg::ST_WAIT;
                  core_clk_en <= 1'b0;
               end
               else if (ir_reg == `OP_STOP)
               begin
                  state_reg <= cpu_slice_pkg::ST_STOP;
                  core_clk_en <= 1'b0;
               end
               else
                  state_reg <= cpu_slice_pkg::ST_IDLE;
            end
            cpu_slice_pkg::ST_WAIT:
            begin
               if (!irq_sync_n)
               begin
                  state_reg <= cpu_slice_pkg::ST_IDLE;
                  core_clk_en <= 1'b1;
               end
            end
            cpu_slice_pkg::ST_STOP:
            begin
               if (!irq_sync_n)
               begin
                  state_reg <= cpu_slice_pkg::ST_STAB;
                  stab_reg <= 13'(STAB_COUNT - 1);
               end
            end
            cpu_slice_pkg::ST_STAB:
            begin
               // Clock held off until the oscillator has settled
               if (stab_reg == 13'h0000)
               begin
                  state_reg <= cpu_slice_pkg::ST_IDLE;
                  core_clk_en <= 1'b1;
               end
               else
                  stab_reg <= stab_reg - 13'h0001;
            end
            default: state_reg <= cpu_slice_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Instruction register, PC and break state
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ir_reg <= 8'h00;
         pc_reg <= `PC_RESET;
         break_active <= 1'b0;
         illegal_reg <= 1'b0;
      end
      else if (break_start)
      begin
         ir_reg <= `OP_TRAP;
         pc_reg <= monitor_reg ? `VEC_TRAP_MON : `VEC_TRAP;
         break_active <= 1'b1;
      end
      else if (state_reg == cpu_slice_pkg::ST_IDLE)
      begin
         if (issue_wr)
         begin
            ir_reg <= pwdata[7:0];
            illegal_reg <= cycles_of(pwdata[7:0]) == `CYC_ILLEGAL &&
                           pwdata[7:0] != `OP_WAIT && pwdata[7:0] != `OP_STOP;
         end
         else if (wr_en && paddr == `OFS_PC)
            pc_reg <= 16'(lane_merge({16'h0000, pc_reg}, pwdata, pstrb));
      end
      else if (last_cycle)
      begin
         if (is_branch)
            pc_reg <= br_taken ? br_target : pc_reg + 16'h0002;
         else if (ir_reg == `OP_TRAP)
            pc_reg <= `VEC_TRAP;
         else if (ir_reg == `OP_STACK_ADD || ir_reg == `OP_INDEX_ADD ||
                  ir_reg == `OP_ADD_IMM || ir_reg == `OP_SUB_IMM)
            pc_reg <= pc_reg + 16'h0002;
         else if (ir_reg != `OP_RETURN)
            pc_reg <= pc_reg + 16'h0001;
         if (ir_reg == `OP_RETURN && break_active && !brk_sync)
            break_active <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Stack pointer, index pair and accumulator
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sp_reg <= `SP_RESET;
         hx_reg <= 16'h0000;
         acc_reg <= 8'h00;
      end
      else if (last_cycle)
      begin
         if (ir_reg == `OP_STACK_ADD)
            sp_reg <= sp_reg + imm_sext;
         if (ir_reg == `OP_INDEX_ADD)
            hx_reg <= hx_reg + imm_sext;
         if (ir_reg == `OP_ADD_IMM)
            acc_reg <= add_sum[7:0];
         if (ir_reg == `OP_SUB_IMM)
            acc_reg <= sub_diff[7:0];
      end
      else if (wr_en && state_reg == cpu_slice_pkg::ST_IDLE)
      begin
         if (paddr == `OFS_SP)
            sp_reg <= 16'(lane_merge({16'h0000, sp_reg}, pwdata, pstrb));
         if (paddr == `OFS_HX)
            hx_reg <= 16'(lane_merge({16'h0000, hx_reg}, pwdata, pstrb));
         if (paddr == `OFS_ACC && pstrb[0])
            acc_reg <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Condition codes
   // ------------------------------------------------------------
   // Software may load V, H, N, Z and C for the neighbouring flag logic;
   // the mask is never writable, so reset state survives until cleared by code
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ccr_reg <= `CCR_FIXED | (8'h01 << `CCR_I);
         saved_mask_reg <= 1'b1;
      end
      else if (break_start)
      begin
         saved_mask_reg <= ccr_reg[`CCR_I];
         ccr_reg[`CCR_I] <= 1'b1;
      end
      else if (last_cycle)
      begin
         case (ir_reg)
            `OP_ADD_IMM: ccr_reg[`CCR_C] <= add_sum[8];
            `OP_SUB_IMM: ccr_reg[`CCR_C] <= sub_diff[8];
            `OP_CLEAR_MASK: ccr_reg[`CCR_I] <= 1'b0;
            `OP_SET_MASK: ccr_reg[`CCR_I] <= 1'b1;
            `OP_WAIT: ccr_reg[`CCR_I] <= 1'b0;
            `OP_STOP: ccr_reg[`CCR_I] <= 1'b0;
            `OP_TRAP:
            begin
               saved_mask_reg <= ccr_reg[`CCR_I];
               ccr_reg[`CCR_I] <= 1'b1;
            end
            `OP_RETURN: ccr_reg[`CCR_I] <= saved_mask_reg;
            default: ccr_reg <= ccr_reg;
         endcase
      end
      else if (wr_en && paddr == `OFS_CCR && pstrb[0] && state_reg == cpu_slice_pkg::ST_IDLE)
      begin
         ccr_reg[`CCR_V] <= pwdata[`CCR_V];
         ccr_reg[`CCR_H] <= pwdata[`CCR_H];
         ccr_reg[`CCR_N] <= pwdata[`CCR_N];
         ccr_reg[`CCR_Z] <= pwdata[`CCR_Z];
         ccr_reg[`CCR_C] <= pwdata[`CCR_C];
      end
   end
endmodule // cpu_slice

// *** core/cpu_slice_regs.svh ***
/*
 * Register offsets, field positions, reset values, opcodes and timing counts
 * for the flag, low-power, break and branch slice of the core.
 * Assumes inclusion by bare name from the top module, the branch evaluator, the checker and the bench.
 */
`ifndef CPU_SLICE_REGS_SVH
`define CPU_SLICE_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_OPERAND 8'h04
`define OFS_ISSUE 8'h08
`define OFS_CCR 8'h0c
`define OFS_ACC 8'h10
`define OFS_SP 8'h14
`define OFS_HX 8'h18
`define OFS_PC 8'h1c
`define OFS_STATUS 8'h20

// ------------------------------------------------------------
// Condition code bit positions
// ------------------------------------------------------------
`define CCR_C 0
`define CCR_Z 1
`define CCR_N 2
`define CCR_I 3
`define CCR_H 4
`define CCR_V 7
`define CCR_FIXED 8'h60

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SP_RESET 16'h00ff
`define PC_RESET 16'hfffe

// ------------------------------------------------------------
// Vectors
// ------------------------------------------------------------
`define VEC_TRAP 16'hfffc
`define VEC_TRAP_MON 16'hfefc

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define OP_STACK_ADD 8'ha7
`define OP_INDEX_ADD 8'haf
`define OP_ADD_IMM 8'hab
`define OP_SUB_IMM 8'ha0
`define OP_NO_CARRY 8'h24
`define OP_CARRY 8'h25
`define OP_ZERO 8'h27
`define OP_NO_HALF 8'h28
`define OP_HALF 8'h29
`define OP_SIGNED_GE 8'h90
`define OP_SIGNED_GT 8'h92
`define OP_CLEAR_MASK 8'h9a
`define OP_SET_MASK 8'h9b
`define OP_WAIT 8'h8f
`define OP_STOP 8'h8e
`define OP_TRAP 8'h83
`define OP_RETURN 8'h80

// ------------------------------------------------------------
// Cycle counts
// ------------------------------------------------------------
`define CYC_IMM_ADD 4'd2
`define CYC_BRANCH 4'd3
`define CYC_MASK 4'd2
`define CYC_LOWPOWER 4'd1
`define CYC_TRAP 4'd9
`define CYC_RETURN 4'd7
`define CYC_ILLEGAL 4'd1
`define STAB_CYCLES 4096

`endif

// *** core/cpu_slice_pkg.sv ***
/*
 * Types shared by the core slice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpu_slice_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EXEC,
      ST_WAIT,
      ST_STOP,
      ST_STAB
   } exec_state_t;
endpackage

// *** core/sync_bit.sv ***
/*
 * Two-flop synchroniser for one pin level.
 * Assumes the pin is asynchronous to clk; reset value is a parameter.
 */
module sync_bit #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= RESET_VAL;
         q <= RESET_VAL;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sync_bit

// *** core/branch_eval.sv ***
/*
 * Relative branch condition and target for the conditional branches.
 * Assumes pc is the address of the branch opcode.
 */
module branch_eval (
   input wire logic [7:0] opcode,
   input wire logic [7:0] ccr,
   input wire logic [15:0] pc,
   input wire logic [7:0] offset,
   output logic is_branch,
   output logic taken,
   output logic [15:0] target
);
`include "cpu_slice_regs.svh"
   logic c, z, n, h, v;

   assign c = ccr[`CCR_C];
   assign z = ccr[`CCR_Z];
   assign n = ccr[`CCR_N];
   assign h = ccr[`CCR_H];
   assign v = ccr[`CCR_V];
   // Offset is two's complement, widened before the add
   assign target = pc + 16'h0002 + {{8{offset[7]}}, offset};

   always_comb
   begin
      is_branch = 1'b1;
      taken = 1'b0;
      case (opcode)
         `OP_NO_CARRY: taken = ~c;
         `OP_CARRY: taken = c;
         `OP_ZERO: taken = z;
         `OP_SIGNED_GE: taken = ~(n ^ v);
         `OP_SIGNED_GT: taken = ~(z | (n ^ v));
         `OP_NO_HALF: taken = ~h;
         `OP_HALF: taken = h;
         default: is_branch = 1'b0;
      endcase
   end
endmodule // branch_eval

// *** test/cpu_slice_asserts.sv ***
/*
 * Port checker for the core slice: low-power entry and exit, break entry and exit.
 * Assumes it is bound to cpu_slice and that the slice header is on the include path.
 */
`include "cpu_slice_regs.svh"
module cpu_slice_asserts #(
   parameter int STAB_COUNT = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq_n,
   input wire logic break_req,
   input wire logic core_clk_en,
   input wire logic break_active
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WAKE_MAX = STAB_COUNT + 6;
   logic [15:0] irq_cnt;
   logic stop_seen;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Helpers: cycles since the wake pin went low, last sleep kind
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_cnt <= 16'h0000;
      else if (irq_n)
         irq_cnt <= 16'h0000;
      else if (irq_cnt != 16'hffff)
         irq_cnt <= irq_cnt + 16'h0001;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stop_seen <= 1'b0;
      else if (psel && !penable && pwrite && paddr == `OFS_ISSUE)
         stop_seen <= (pwdata[7:0] == `OP_STOP);
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_lp_entry;
      $fell(core_clk_en) |-> $past(psel && penable && pwrite && paddr == `OFS_ISSUE, 2)
         && ($past(pwdata[7:0], 2) inside {`OP_WAIT, `OP_STOP});
   endproperty
   a_lp_entry: assert property (p_lp_entry)
      else $error("clock gated without a sleep opcode");
   property p_lp_hold;
      !core_clk_en && !stop_seen && irq_n && $past(irq_n) && $past(irq_n, 2) |=> !core_clk_en;
   endproperty
   a_lp_hold: assert property (p_lp_hold)
      else $error("wait left without a wake request");
   property p_wait_wake;
      $rose(core_clk_en) && !stop_seen |-> irq_cnt >= 16'd2 && irq_cnt <= 16'd4;
   endproperty
   a_wait_wake: assert property (p_wait_wake)
      else $error("wait exit not tied to the wake pin");
   property p_stop_stab;
      $rose(core_clk_en) && stop_seen |-> irq_cnt >= STAB_COUNT + 2 && irq_cnt <= STAB_COUNT + 4;
   endproperty
   a_stop_stab: assert property (p_stop_stab)
      else $error("stop exit ignored the settling delay");
   property p_wake_bound;
      $fell(irq_n) && !core_clk_en |-> ##[1:WAKE_MAX] core_clk_en;
   endproperty
   a_wake_bound: assert property (p_wake_bound)
      else $error("clock not restored after wake");
   property p_break_start;
      $rose(break_active) |-> $past(break_req) && $past(break_req, 2);
   endproperty
   a_break_start: assert property (p_break_start)
      else $error("break entered without a request");
   property p_break_hold;
      break_active && break_req && $past(break_req) && $past(break_req, 2) |=> break_active;
   endproperty
   a_break_hold: assert property (p_break_hold)
      else $error("break ended while still requested");
   property p_break_end;
      $fell(break_active) |-> !$past(break_req, 2) && !$past(break_req, 3);
   endproperty
   a_break_end: assert property (p_break_end)
      else $error("break ended with request high");
endmodule // cpu_slice_asserts

bind cpu_slice cpu_slice_asserts #(.STAB_COUNT(STAB_COUNT)) u_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_n(irq_n), .break_req(break_req), .core_clk_en(core_clk_en),
   .break_active(break_active));

// *** test/tb.sv ***
/*
 * Self-checking bench for the core slice, driven over APB and its pins.
 * Assumes the slice header on the include path; settling count shortened to 8.
 */
`include "cpu_slice_regs.svh"
`define CHK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("unexpected %s: expected %h, seen %h", what, exp, got); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STAB = 8;
   logic pclk, presetn, psel, penable, pwrite, pslverr, pready, irq_n, break_req;
   logic core_clk_en, break_active, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] pstrb;
   int failures, n_tests;
   cpu_slice #(.STAB_COUNT(STAB)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_n(irq_n),
      .break_req(break_req), .core_clk_en(core_clk_en), .break_active(break_active));
   always #2.5 pclk = ~pclk;
   // ------------------------------------------------------------
   // Bus and issue tasks
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Sleep opcodes never report idle, so the caller decides whether to poll
   task automatic issue(input logic [7:0] op, input logic [7:0] opd, input logic poll);
      apb(1'b1, `OFS_OPERAND, {24'h0, opd});
      apb(1'b1, `OFS_ISSUE, {24'h0, op});
      while (poll)
      begin
         apb(1'b0, `OFS_STATUS, 32'h0);
         poll = (rdata[3:0] !== 4'h0);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      apb(1'b0, `OFS_CCR, 32'h0);
      `CHK("ccr", 32'h0000_0068, rdata)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped err", 1'b1, rerr)
   endtask
   task automatic t_arith();
      logic [7:0] a [3] = '{8'hff, 8'h10, 8'h20};
      logic [7:0] b [3] = '{8'h01, 8'h20, 8'h10};
      logic [7:0] o [3] = '{`OP_ADD_IMM, `OP_SUB_IMM, `OP_SUB_IMM};
      logic c [3] = '{1'b1, 1'b1, 1'b0};
      apb(1'b1, `OFS_SP, 32'h0000_0100);
      issue(`OP_STACK_ADD, 8'h80, 1'b1);
      apb(1'b0, `OFS_SP, 32'h0);
      `CHK("sp", 32'h0000_0080, rdata)
      apb(1'b1, `OFS_HX, 32'h0000_1234);
      issue(`OP_INDEX_ADD, 8'h7f, 1'b1);
      apb(1'b0, `OFS_HX, 32'h0);
      `CHK("hx", 32'h0000_12b3, rdata)
      apb(1'b0, `OFS_CCR, 32'h0);
      `CHK("ccr kept", 32'h0000_0068, rdata)
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, `OFS_ACC, {24'h0, a[i]});
         issue(o[i], b[i], 1'b1);
         apb(1'b0, `OFS_CCR, 32'h0);
         `CHK("carry", c[i], rdata[`CCR_C])
      end
   endtask
   task automatic t_branch();
      logic [7:0] ops [7] = '{`OP_NO_CARRY, `OP_CARRY, `OP_ZERO, `OP_NO_HALF, `OP_HALF,
         `OP_SIGNED_GE, `OP_SIGNED_GT};
      logic [7:0] fl [3] = '{8'h00, 8'h97, 8'h04};
      logic [7:0] f, off;
      logic tk;
      logic [15:0] pc;
      for (int i = 0; i < 21; i++)
      begin
         f = fl[i % 3];
         off = (i % 2 == 1) ? 8'hf0 : 8'h10;
         case (ops[i / 3])
            `OP_NO_CARRY: tk = !f[`CCR_C];
            `OP_CARRY: tk = f[`CCR_C];
            `OP_ZERO: tk = f[`CCR_Z];
            `OP_NO_HALF: tk = !f[`CCR_H];
            `OP_HALF: tk = f[`CCR_H];
            `OP_SIGNED_GE: tk = !(f[`CCR_N] ^ f[`CCR_V]);
            default: tk = !(f[`CCR_Z] | (f[`CCR_N] ^ f[`CCR_V]));
         endcase
         pc = 16'h1002 + (tk ? {{8{off[7]}}, off} : 16'h0000);
         apb(1'b1, `OFS_CCR, {24'h0, f});
         apb(1'b1, `OFS_PC, 32'h0000_1000);
         issue(ops[i / 3], off, 1'b1);
         apb(1'b0, `OFS_PC, 32'h0);
         `CHK("branch pc", {16'h0, pc}, rdata)
         apb(1'b0, `OFS_CCR, 32'h0);
         `CHK("branch ccr", {24'h0, f | 8'h68}, rdata)
      end
   endtask
   task automatic t_sleep(input logic stop);
      issue(stop ? `OP_STOP : `OP_WAIT, 8'h00, 1'b0);
      repeat (4) @(posedge pclk);
      `CHK("gated", 1'b0, core_clk_en)
      irq_n <= 1'b0;
      repeat (STAB) @(posedge pclk);
      `CHK("still gated", !stop, core_clk_en)
      repeat (10) @(posedge pclk);
      `CHK("woken", 1'b1, core_clk_en)
      irq_n <= 1'b1;
      apb(1'b0, `OFS_CCR, 32'h0);
      `CHK("mask after wake", 1'b0, rdata[`CCR_I])
      issue(`OP_SET_MASK, 8'h00, 1'b1);
      issue(`OP_WAIT, 8'h00, 1'b0);
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_CCR, 32'h0);
      `CHK("mask after reset", 1'b1, rdata[`CCR_I])
   endtask
   task automatic t_break();
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, `OFS_CTRL, m);
         break_req <= 1'b1;
         repeat (6) @(posedge pclk);
         `CHK("break on", 1'b1, break_active)
         apb(1'b0, `OFS_ISSUE, 32'h0);
         `CHK("forced op", {24'h0, `OP_TRAP}, rdata)
         apb(1'b0, `OFS_PC, 32'h0);
         `CHK("vector", {16'h0, m ? `VEC_TRAP_MON : `VEC_TRAP}, rdata)
         issue(`OP_RETURN, 8'h00, 1'b1);
         `CHK("break held", 1'b1, break_active)
         break_req <= 1'b0;
         repeat (4) @(posedge pclk);
         issue(`OP_RETURN, 8'h00, 1'b1);
         `CHK("break off", 1'b0, break_active)
      end
   endtask
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      irq_n = 1'b1;
      break_req = 1'b0;
      failures = 0;
      n_tests = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_arith();
      t_branch();
      t_sleep(1'b0);
      t_sleep(1'b1);
      t_break();
      summarize();
   end
   // Generous ceiling: the whole sequence needs under a thousand cycles
   initial
   begin
      repeat (30000) @(posedge pclk);
      failures++;
      summarize();
   end
endmodule // tb
